// file: fp_behavior_pkg.sv
// package: register map, control field layout and datapath control types
package fp_behavior_pkg;
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [11:0] ID_ADDR = 12'h008;
	localparam int FIZ_BIT = 0;
	localparam int AH_BIT = 1;
	localparam int NEP_BIT = 2;
	localparam int EBF_BIT = 13;
	localparam int TRAP_LSB = 14;
	localparam int HALF_FLUSH_BIT = 20;
	localparam int RMODE_LSB = 22;
	localparam int FZ_BIT = 24;
	localparam int DN_BIT = 25;
	localparam int AHP_BIT = 26;
	localparam int FLAG_W = 6;
	localparam logic [31:0] CTRL_WMASK = 32'h07DF_E007;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [FLAG_W-1:0] STATUS_RESET = 6'h00;
	localparam int ID_VEC_LSB = 0;
	localparam int ID_ISA_LSB = 4;
	localparam logic [3:0] BF_ID_EXT = 4'h2;
	localparam logic [3:0] BF_ID_BASIC = 4'h1;

	typedef enum logic [1:0] {
		OP_BF_SOP,
		OP_ZA_FP,
		OP_STREAM_FP,
		OP_OTHER_FP
	} op_class_e;

	typedef enum logic [1:0] {
		FMT_HALF,
		FMT_SINGLE,
		FMT_DOUBLE,
		FMT_ALT_HALF
	} fmt_e;

	typedef struct packed {
		logic valid;
		op_class_e cls;
		fmt_e fmt;
		logic any_nan_in;
		logic inf_times_zero;
		logic pos_inf_prod;
		logic neg_inf_prod;
		logic [FLAG_W-1:0] exc;
	} op_req_s;

	typedef struct packed {
		logic valid;
		logic [1:0] rmode;
		logic round_odd;
		logic flush_in;
		logic flush_out;
		logic flush_after_round;
		logic default_nan;
		logic nan_sign;
		logic fused_pairs;
		logic alt_half;
		logic half_flush;
		logic flags_update;
		logic fmt_illegal;
		logic sop_nan;
		logic sop_inf;
		logic sop_inf_sign;
		logic [FLAG_W-1:0] trap_en;
		logic element_preserve_ctrl;
	} op_ctrl_s;
endpackage

// file: fp_behavior_resolve.sv
// combinational resolver: effective controls for one floating-point operation
`timescale 1ns/1ps
module fp_behavior_resolve
	import fp_behavior_pkg::*;
#(
	parameter bit EBF_IMPL = 1'b1,
	parameter bit AFP_IMPL = 1'b1
) (
	input wire op_req_s req,
	input wire logic [31:0] fp_control_register,
	input wire logic streaming,
	input wire logic full_isa_en,
	output op_ctrl_s ctrl
);
	wire ebf_on = EBF_IMPL & fp_control_register[EBF_BIT];
	wire ah = AFP_IMPL & fp_control_register[AH_BIT];
	wire fiz = AFP_IMPL & fp_control_register[FIZ_BIT];
	wire fz = fp_control_register[FZ_BIT];
	wire is_bf = req.cls == OP_BF_SOP;
	wire is_za = req.cls == OP_ZA_FP;
	wire sd_fmt = (req.fmt == FMT_SINGLE) | (req.fmt == FMT_DOUBLE);
	wire trap_zero = streaming & ~full_isa_en;
	wire in_std = (fz & ~ah) | fiz;
	// flushing: standard bf forces both, extended follows the controls
	wire bf_flush_in = ebf_on ? in_std : 1'b1;
	wire za_flush_in = (fz & ~ah) | (fiz & sd_fmt);
	wire any_inf = req.pos_inf_prod | req.neg_inf_prod;
	wire nan_src = req.any_nan_in | req.inf_times_zero;
	wire sop_nan = nan_src | (req.pos_inf_prod & req.neg_inf_prod);
	wire ext_bf = is_bf & ebf_on;

	assign ctrl.valid = req.valid;
	assign ctrl.rmode = fp_control_register[RMODE_LSB +: 2];
	assign ctrl.round_odd = is_bf & ~ebf_on;
	assign ctrl.flush_in = is_bf ? bf_flush_in : (is_za ? za_flush_in : in_std);
	assign ctrl.flush_out = (is_bf & ~ebf_on) | fz;
	assign ctrl.flush_after_round = ah & fz & (~is_bf | ebf_on);
	assign ctrl.default_nan = is_bf | is_za | fp_control_register[DN_BIT];
	assign ctrl.nan_sign = ah & (~is_bf | ebf_on);
	assign ctrl.fused_pairs = ext_bf;
	assign ctrl.alt_half = fp_control_register[AHP_BIT] & ~is_za;
	assign ctrl.half_flush = fp_control_register[HALF_FLUSH_BIT];
	assign ctrl.flags_update = ~(is_bf | is_za);
	assign ctrl.fmt_illegal = is_za & (req.fmt == FMT_ALT_HALF);
	assign ctrl.sop_nan = ext_bf & sop_nan;
	assign ctrl.sop_inf = ext_bf & ~sop_nan & any_inf;
	assign ctrl.sop_inf_sign = req.neg_inf_prod;
	assign ctrl.trap_en = trap_zero ? '0 : fp_control_register[TRAP_LSB +: FLAG_W];
	assign ctrl.element_preserve_ctrl = ~trap_zero & fp_control_register[NEP_BIT];
endmodule

// file: fp_behavior_ctrl.sv
// top: apb control/status registers and registered per-operation controls
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module fp_behavior_ctrl
	import fp_behavior_pkg::*;
#(
	parameter bit EBF_IMPL = 1'b1,
	parameter bit AFP_IMPL = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic streaming_mode,
	input wire logic full_isa_en,
	input wire op_req_s req,
	output op_ctrl_s ctrl
);
	logic [31:0] fp_control_register;
	logic [FLAG_W-1:0] fp_status_register;
	op_ctrl_s next_ctrl;

	// apb decode
	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire hit_ctrl = paddr == CTRL_ADDR;
	wire hit_status = paddr == STATUS_ADDR;
	wire hit_id = paddr == ID_ADDR;
	wire mapped = hit_ctrl | hit_status | hit_id;

	// feature identification
	wire [3:0] id_field = EBF_IMPL ? BF_ID_EXT : BF_ID_BASIC;
	wire [31:0] id_word = {24'h000000, id_field, id_field};

	// enable bit only exists with the extended feature
	wire [31:0] ebf_mask = 32'h0000_0001 << EBF_BIT;
	wire [31:0] wmask = EBF_IMPL ? CTRL_WMASK : CTRL_WMASK & ~ebf_mask;
	wire [31:0] next_fp_control_register = (wr & hit_ctrl) ? (pwdata & wmask) : fp_control_register;

	// flag accumulation; a hardware set wins over a software write
	wire flag_go = req.valid & next_ctrl.flags_update;
	wire [FLAG_W-1:0] flag_set = flag_go ? req.exc : '0;
	wire [FLAG_W-1:0] wr_fp_status_register = pwdata[FLAG_W-1:0];
	wire [FLAG_W-1:0] base_fp_status_register = (wr & hit_status) ? wr_fp_status_register : fp_status_register;
	wire [FLAG_W-1:0] next_fp_status_register = base_fp_status_register | flag_set;

	// read mux: stored values, never the effective ones
	wire [31:0] status_word = {26'h0, fp_status_register};
	wire [31:0] rd_ctrl = hit_ctrl ? fp_control_register : 32'h0000_0000;
	wire [31:0] rd_status = hit_status ? status_word : 32'h0000_0000;
	wire [31:0] rd_id = hit_id ? id_word : 32'h0000_0000;
	wire [31:0] next_prdata = rd_ctrl | rd_status | rd_id;

	fp_behavior_resolve #(
		.EBF_IMPL(EBF_IMPL),
		.AFP_IMPL(AFP_IMPL)
	) resolve (
		.req(req),
		.fp_control_register(fp_control_register),
		.streaming(streaming_mode),
		.full_isa_en(full_isa_en),
		.ctrl(next_ctrl)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fp_control_register <= CTRL_RESET;
			fp_status_register <= STATUS_RESET;
		end else begin
			fp_control_register <= next_fp_control_register;
			fp_status_register <= next_fp_status_register;
		end
	end

	// zero-wait slave: data captured in setup, ready in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= setup ? next_prdata : prdata;
			pready <= setup;
			pslverr <= setup & ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// checks
	wire ebf_on = EBF_IMPL & fp_control_register[EBF_BIT];
	wire bf_op = req.valid & (req.cls == OP_BF_SOP);
	wire za_op = req.valid & (req.cls == OP_ZA_FP);
	wire st_op = req.valid & (req.cls == OP_STREAM_FP);
	wire oth_op = req.valid & (req.cls == OP_OTHER_FP);
	wire st_wr = wr & hit_status;
	wire ah_on = AFP_IMPL & fp_control_register[AH_BIT];
	wire fz_on = fp_control_register[FZ_BIT];
	wire fiz_on = AFP_IMPL & fp_control_register[FIZ_BIT];
	wire sd_fmt = (req.fmt == FMT_SINGLE) | (req.fmt == FMT_DOUBLE);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence apb_setup;
		psel && !penable;
	endsequence

	sequence apb_done;
		pready ##1 !pready;
	endsequence

	sequence bf_std_issue;
		bf_op && !ebf_on;
	endsequence

	sequence bf_ext_issue;
		bf_op && ebf_on;
	endsequence

	chk_apb_one_wait: assert property (
		apb_setup |=> apb_done
	) else $error("apb ready not one cycle after setup");

	chk_apb_unmapped: assert property (
		apb_setup and !mapped |=> pslverr && pready
	) else $error("unmapped access without error");

	chk_ebf_bit_store: assert property (
		wr && hit_ctrl |=> fp_control_register[EBF_BIT] == (EBF_IMPL & $past(pwdata[EBF_BIT]))
	) else $error("enable bit not stored at bit 13");

	chk_id_field_value: assert property (
		access && !pwrite && hit_id |->
		prdata[7:0] == (EBF_IMPL ? {BF_ID_EXT, BF_ID_EXT} : {BF_ID_BASIC, BF_ID_BASIC})
	) else $error("id brainfloat fields wrong");

	chk_bf_std_round: assert property (
		bf_op && !ebf_on |=> ctrl.round_odd && !ctrl.fused_pairs
	) else $error("standard bf not round to odd");

	chk_bf_ext_round: assert property (
		bf_op && ebf_on |=> !ctrl.round_odd && ctrl.rmode == $past(fp_control_register[23:22])
	) else $error("extended bf rounding mode lost");

	chk_bf_flags_hold: assert property (
		(bf_op || za_op) && !st_wr |=> fp_status_register == $past(fp_status_register)
	) else $error("bf or array op changed flags");

	chk_default_nan: assert property (
		bf_op || za_op |=> ctrl.default_nan
	) else $error("default nan not forced");

	chk_bf_std_flush: assert property (
		bf_op && !ebf_on |=> ctrl.flush_in && ctrl.flush_out
	) else $error("standard bf not flushing");

	chk_bf_fused: assert property (
		bf_op |=> ctrl.fused_pairs == $past(ebf_on)
	) else $error("fusion does not track enable");

	chk_sop_nan: assert property (
		bf_op && ebf_on && req.pos_inf_prod && req.neg_inf_prod
		|=> ctrl.sop_nan && !ctrl.sop_inf
	) else $error("mixed infinities not nan");

	chk_sop_inf: assert property (
		bf_op && ebf_on && !req.any_nan_in && !req.inf_times_zero
		&& req.neg_inf_prod && !req.pos_inf_prod
		|=> ctrl.sop_inf && ctrl.sop_inf_sign
	) else $error("same-sign infinity lost");

	chk_nan_sign: assert property (
		bf_op && ebf_on && ah_on |=> ctrl.nan_sign
	) else $error("default nan sign not set");

	chk_ah_input_flush: assert property (
		bf_op && ebf_on && ah_on && !fiz_on |=> !ctrl.flush_in
	) else $error("inputs flushed under alternate");

	chk_ah_out_flush: assert property (
		bf_op && ebf_on && ah_on && fz_on |=> ctrl.flush_after_round
	) else $error("rounded denormal not flushed");

	chk_stream_flags: assert property (
		st_op && !st_wr ##1 1'b1 |-> (fp_status_register & $past(req.exc)) == $past(req.exc)
	) else $error("streaming flags not set");

	chk_trap_masked: assert property (
		streaming_mode && !full_isa_en |=> ctrl.trap_en == '0 && !ctrl.element_preserve_ctrl
	) else $error("traps not masked in streaming");

	chk_za_alt_half: assert property (
		za_op && req.fmt == FMT_ALT_HALF |=> ctrl.fmt_illegal
	) else $error("alt half accepted by array op");

	chk_za_fiz_flush: assert property (
		za_op && fiz_on && sd_fmt |=> ctrl.flush_in
	) else $error("array input not flushed");

	chk_ctrl_read_back: assert property (
		access && !pwrite && hit_ctrl |-> prdata == $past(fp_control_register)
	) else $error("control read not the stored value");

	chk_ctrl_write_mask: assert property (
		wr && hit_ctrl |=> fp_control_register == ($past(pwdata) & wmask)
	) else $error("control write not masked");

	chk_ctrl_hold: assert property (
		!(wr && hit_ctrl) |=> $stable(fp_control_register)
	) else $error("control changed without write");

	chk_unmapped_write: assert property (
		wr && !mapped |=> $stable(fp_control_register)
	) else $error("unmapped write landed");

	chk_prdata_hold: assert property (
		!setup |=> $stable(prdata)
	) else $error("read data moved outside setup");

	chk_status_write: assert property (
		st_wr && !flag_go |=> fp_status_register == $past(wr_fp_status_register)
	) else $error("status write not stored");

	chk_flag_set_wins: assert property (
		st_wr && flag_go |=> (fp_status_register & $past(req.exc)) == $past(req.exc)
	) else $error("status write beat a flag set");

	chk_ctrl_valid: assert property (
		1'b1 |=> ctrl.valid == $past(req.valid)
	) else $error("ctrl valid not one cycle late");

	chk_bf_no_flags: assert property (
		bf_op |=> !ctrl.flags_update
	) else $error("bf op would update flags");

	chk_bf_std_unfused: assert property (
		bf_std_issue |=> !ctrl.fused_pairs
	) else $error("standard bf fused");

	chk_bf_std_plain: assert property (
		bf_std_issue |=> !ctrl.sop_nan && !ctrl.sop_inf
		&& !ctrl.nan_sign && !ctrl.flush_after_round
	) else $error("extended behaviour while disabled");

	chk_ext_flush_out: assert property (
		bf_ext_issue |=> ctrl.flush_out == $past(fz_on)
	) else $error("extended output flush not fz");

	chk_ext_flush_in: assert property (
		bf_ext_issue ##0 (!ah_on && !fiz_on) |=> ctrl.flush_in == $past(fz_on)
	) else $error("extended input flush not fz");

	chk_fiz_input_flush: assert property (
		bf_ext_issue ##0 fiz_on |=> ctrl.flush_in
	) else $error("fiz did not flush inputs");

	chk_sop_nan_input: assert property (
		bf_ext_issue ##0 (req.any_nan_in || req.inf_times_zero)
		|=> ctrl.sop_nan && !ctrl.sop_inf
	) else $error("nan input or inf times zero not nan");

	chk_sop_inf_pos: assert property (
		bf_ext_issue ##0 (!req.any_nan_in && !req.inf_times_zero)
		##0 (req.pos_inf_prod && !req.neg_inf_prod)
		|=> ctrl.sop_inf && !ctrl.sop_inf_sign
	) else $error("positive infinity lost");

	chk_stream_rmode: assert property (
		st_op |=> ctrl.rmode == $past(fp_control_register[RMODE_LSB +: 2])
	) else $error("streaming rounding mode lost");

	chk_stream_half: assert property (
		st_op |=> ctrl.alt_half == $past(fp_control_register[AHP_BIT])
		&& ctrl.half_flush == $past(fp_control_register[HALF_FLUSH_BIT])
	) else $error("streaming half controls lost");

	chk_stream_dn: assert property (
		st_op |=> ctrl.default_nan == $past(fp_control_register[DN_BIT])
	) else $error("streaming default nan not dn");

	chk_stream_flush: assert property (
		st_op |=> ctrl.flush_out == $past(fz_on)
	) else $error("streaming output flush not fz");

	chk_stream_ah_sign: assert property (
		st_op |=> ctrl.nan_sign == $past(ah_on)
	) else $error("streaming nan sign not ah");

	chk_stream_update: assert property (
		st_op |=> ctrl.flags_update
	) else $error("streaming op not updating flags");

	chk_other_update: assert property (
		oth_op |=> ctrl.flags_update
	) else $error("plain op not updating flags");

	chk_trap_pass: assert property (
		!(streaming_mode && !full_isa_en) |=>
		ctrl.trap_en == $past(fp_control_register[TRAP_LSB +: FLAG_W])
		&& ctrl.element_preserve_ctrl == $past(fp_control_register[NEP_BIT])
	) else $error("traps lost outside masking");

	chk_za_no_flags: assert property (
		za_op |=> !ctrl.flags_update
	) else $error("array op would update flags");

	chk_za_flags_hold: assert property (
		za_op && !st_wr |=> fp_status_register == $past(fp_status_register)
	) else $error("array op changed flags");

	chk_za_rmode: assert property (
		za_op |=> ctrl.rmode == $past(fp_control_register[RMODE_LSB +: 2])
	) else $error("array rounding mode lost");

	chk_za_no_alt_half: assert property (
		za_op |=> !ctrl.alt_half
	) else $error("alt half used by array op");

	chk_za_fmt_legal: assert property (
		za_op && req.fmt != FMT_ALT_HALF |=> !ctrl.fmt_illegal
	) else $error("ieee format refused by array op");

	chk_za_ah_input: assert property (
		za_op && ah_on && !fiz_on |=> !ctrl.flush_in
	) else $error("array inputs flushed under alternate");
endmodule

// file: fp_issue_model.sv
// partner model: pipeline issue stage handing one op per go strobe
`timescale 1ns/1ps
module fp_issue_model
	import fp_behavior_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire op_req_s op_in,
	output op_req_s req
);
	// one op per strobe, dropped to idle after one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) req <= '0;
		else req <= go ? op_in : '0;
	end
endmodule

// file: tb_fp_behavior_ctrl.sv
// testbench: control/status registers and resolved op controls
`timescale 1ns/1ps
module tb_fp_behavior_ctrl
	import fp_behavior_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, go = 0, strm = 0, fisa = 0;
	op_req_s op_in = '0, req;
	op_ctrl_s ctrl, c;
	int errors = 0, samples_checked = 0;
	fp_issue_model pm (.pclk(pclk), .presetn(presetn), .go(go),
		.op_in(op_in), .req(req));
	fp_behavior_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.streaming_mode(strm), .full_isa_en(fisa), .req(req), .ctrl(ctrl));
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	task results;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task op(input op_class_e k, input fmt_e f, input logic [3:0] sp,
		input logic [5:0] x);
		@(posedge pclk);
		go <= 1;
		op_in <= '{1'b1, k, f, sp[3], sp[2], sp[1], sp[0], x};
		@(posedge pclk);
		go <= 0;
		repeat (2) @(posedge pclk);
		c = ctrl;
		chk(c.valid, 1);
	endtask
	task t_regs;
		apb(0, ID_ADDR, 0);
		chk(q, 32'h0000_0022);
		apb(0, CTRL_ADDR, 0);
		chk(q, CTRL_RESET);
		apb(0, 12'h00C, 0);
		chk(e, 1);
		chk(q, 32'h0);
		apb(1, CTRL_ADDR, 32'h0000_2000);
		apb(0, CTRL_ADDR, 0);
		chk(q, 32'h0000_2000);
	endtask
	task t_std;
		apb(1, CTRL_ADDR, 32'h0040_0000);
		op(OP_BF_SOP, FMT_SINGLE, 4'h0, 6'h3F);
		chk({c.round_odd, c.flush_in, c.flush_out}, 3'h7);
		chk({c.fused_pairs, c.default_nan}, 2'h1);
		chk(c.flags_update, 0);
		apb(0, STATUS_ADDR, 0);
		chk(q, 32'h0);
	endtask
	task t_ext;
		int m;
		apb(1, CTRL_ADDR, 32'h0100_2000);
		op(OP_BF_SOP, FMT_SINGLE, 4'h4, 6'h00);
		chk({c.round_odd, c.fused_pairs, c.sop_nan}, 3'h3);
		chk({c.flush_in, c.flush_out}, 2'h3);
		for (m = 0; m < 4; m++) begin
			apb(1, CTRL_ADDR, 32'h0000_2000 | (m << RMODE_LSB));
			op(OP_BF_SOP, FMT_SINGLE, 4'h0, 6'h00);
			chk(c.rmode, m);
			chk(c.flush_out, 0);
		end
		apb(1, CTRL_ADDR, 32'h0100_2002);
		op(OP_BF_SOP, FMT_SINGLE, 4'h2, 6'h00);
		chk({c.flush_in, c.flush_after_round, c.nan_sign}, 3'h3);
		chk({c.sop_nan, c.sop_inf, c.sop_inf_sign}, 3'h2);
		apb(1, CTRL_ADDR, 32'h0100_2003);
		op(OP_BF_SOP, FMT_SINGLE, 4'h1, 6'h00);
		chk({c.flush_in, c.sop_inf, c.sop_inf_sign}, 3'h7);
	endtask
	task t_strm;
		apb(1, CTRL_ADDR, 32'h04DF_C004);
		strm <= 1;
		fisa <= 0;
		op(OP_STREAM_FP, FMT_HALF, 4'h0, 6'h05);
		chk({c.trap_en, c.element_preserve_ctrl}, 7'h00);
		chk({c.rmode, c.flags_update}, 3'h7);
		chk({c.alt_half, c.half_flush, c.default_nan, c.flush_out}, 4'hC);
		apb(0, CTRL_ADDR, 0);
		chk(q, 32'h04DF_C004);
		apb(0, STATUS_ADDR, 0);
		chk(q, 32'h5);
		fisa <= 1;
		op(OP_STREAM_FP, FMT_DOUBLE, 4'h0, 6'h00);
		chk({c.trap_en, c.element_preserve_ctrl}, 7'h7F);
		strm <= 0;
	endtask
	task t_za;
		apb(1, STATUS_ADDR, 0);
		apb(1, CTRL_ADDR, 32'h0080_0001);
		op(OP_ZA_FP, FMT_ALT_HALF, 4'h0, 6'h0A);
		chk(c.fmt_illegal, 1);
		chk({c.default_nan, c.rmode}, 3'h6);
		chk({c.flush_in, c.flags_update}, 2'h0);
		op(OP_ZA_FP, FMT_SINGLE, 4'h0, 6'h0A);
		chk(c.fmt_illegal, 0);
		chk({c.flush_in, c.flags_update}, 2'h2);
		apb(0, STATUS_ADDR, 0);
		chk(q, 32'h0);
	endtask
	task t_rst;
		op(OP_OTHER_FP, FMT_DOUBLE, 4'h0, 6'h30);
		chk({c.flags_update, c.flush_in}, 2'h3);
		apb(0, STATUS_ADDR, 0);
		chk(q, 32'h30);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, CTRL_ADDR, 0);
		chk(q, CTRL_RESET);
		apb(0, STATUS_ADDR, 0);
		chk(q, STATUS_RESET);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_std;
		t_ext;
		t_strm;
		t_za;
		t_rst;
		results;
	end
	initial begin
		#20000;
		errors++;
		results;
	end
endmodule
